/* File: hwcfg_consts.vh */
// Constants for the hardware configuration register block
`ifndef HWCFG_CONSTS_VH
`define HWCFG_CONSTS_VH
// ----------------------------------------
// Register offset and fields
// ----------------------------------------
`define HWCFG_OFFSET 8'h74
`define HWCFG_REQ_BIT 0
`define HWCFG_TIMEOUT_BIT 1
`define HWCFG_THR_LO 12
`define HWCFG_THR_HI 13
`define HWCFG_THR_RESET 2'h0
`define HWCFG_STFWD_BIT 20
`define HWCFG_STFWD_RESET 1'h0
`define HWCFG_TENM_BIT 21
`define HWCFG_TENM_RESET 1'h0
// ----------------------------------------
// Thresholds in DWORDs
// ----------------------------------------
`define THR_100_0 9'h020
`define THR_100_1 9'h040
`define THR_100_2 9'h080
`define THR_100_3 9'h100
`define THR_10_0 9'h012
`define THR_10_1 9'h018
`define THR_10_2 9'h020
`define THR_10_3 9'h028
// ----------------------------------------
// Soft reset timing
// ----------------------------------------
`define SOFT_RESET_TIMEOUT_NS 100000
`define CLK_PERIOD_NS 25
`define SOFT_RESET_TIMEOUT_CYC (`SOFT_RESET_TIMEOUT_NS / `CLK_PERIOD_NS)
`define PHY_CLK_WINDOW 16
`endif

/* File: phy_clk_monitor.v */
// Detects whether PHY receive and transmit clocks are toggling
`timescale 1ns/100ps
module phy_clk_monitor #(
  parameter WINDOW = 16
) (
  input wire sys_clk,
  input wire rst_n,
  input wire phy_rx_clk_toggle,
  input wire phy_tx_clk_toggle,
  output reg phy_clocks_running
);
  reg [4:0] rx_age;
  reg [4:0] tx_age;
  // Aging counters; a clock seen within the window counts as running
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_age <= 5'h1F;
      tx_age <= 5'h1F;
      phy_clocks_running <= 1'b0;
    end else begin
      if (phy_rx_clk_toggle)
        rx_age <= 5'h00;
      else if (rx_age != 5'h1F)
        rx_age <= rx_age + 5'h01;
      if (phy_tx_clk_toggle)
        tx_age <= 5'h00;
      else if (tx_age != 5'h1F)
        tx_age <= tx_age + 5'h01;
      phy_clocks_running <= (rx_age < WINDOW[4:0]) && (tx_age < WINDOW[4:0]);
    end
  end
endmodule // phy_clk_monitor

/* File: hw_config_soft_reset.v */
// Hardware configuration register: threshold, soft reset, timeout, first-read gate
`timescale 1ns/100ps
`include "hwcfg_consts.vh"
module hw_config_soft_reset #(
  parameter TIMEOUT_CYCLES = `SOFT_RESET_TIMEOUT_CYC,
  parameter CLK_WINDOW = `PHY_CLK_WINDOW
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire power_save_exit,
  input wire phy_rx_clk_toggle,
  input wire phy_tx_clk_toggle,
  input wire tx_fifo_dwords_valid,
  input wire [8:0] tx_fifo_dwords,
  input wire frame_fully_buffered,
  output wire tx_forward_enable,
  output reg [8:0] tx_threshold_dwords,
  output reg mac_soft_reset,
  output reg system_regs_soft_reset,
  output reg error_clear,
  output wire soft_reset_busy
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;
  reg [1:0] state;
  reg [1:0] tx_start_threshold;
  reg store_forward_select;
  reg tx_ten_meg_select;
  reg soft_reset_request;
  reg soft_reset_timeout_flag;
  reg read_seen;
  reg [31:0] wait_count;
  wire phy_clocks_running;
  wire hit;
  wire wr_ok;
  wire wait_expired;

  // A stalled PHY clock shows as stopped after the window
  phy_clk_monitor #(.WINDOW(CLK_WINDOW)) u_mon (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .phy_rx_clk_toggle(phy_rx_clk_toggle),
    .phy_tx_clk_toggle(phy_tx_clk_toggle),
    .phy_clocks_running(phy_clocks_running)
  );

  // ----------------------------------------
  // Threshold lookup
  // ----------------------------------------
  function [8:0] threshold_of;
    input ten_meg;
    input [1:0] code;
    begin
      if (ten_meg) begin
        case (code)
          2'h0: threshold_of = `THR_10_0;
          2'h1: threshold_of = `THR_10_1;
          2'h2: threshold_of = `THR_10_2;
          default: threshold_of = `THR_10_3;
        endcase
      end else begin
        case (code)
          2'h0: threshold_of = `THR_100_0;
          2'h1: threshold_of = `THR_100_1;
          2'h2: threshold_of = `THR_100_2;
          default: threshold_of = `THR_100_3;
        endcase
      end
    end
  endfunction

  // ----------------------------------------
  // Read word assembly
  // ----------------------------------------
  // Reserved bits read as zero so host masks stay simple
  function [31:0] read_word;
    input req;
    input timeout;
    input [1:0] thr_code;
    input stfwd;
    input ten_meg;
    begin
      read_word = 32'h0;
      read_word[`HWCFG_REQ_BIT] = req;
      read_word[`HWCFG_TIMEOUT_BIT] = timeout;
      read_word[`HWCFG_THR_HI:`HWCFG_THR_LO] = thr_code;
      read_word[`HWCFG_STFWD_BIT] = stfwd;
      read_word[`HWCFG_TENM_BIT] = ten_meg;
    end
  endfunction

  // ----------------------------------------
  // Strobes and gates
  // ----------------------------------------
  assign hit = (reg_addr == `HWCFG_OFFSET);
  // Wide counter; a long timeout costs only width
  assign wait_expired = (wait_count >= TIMEOUT_CYCLES - 1);
  assign wr_ok = reg_wr && hit && read_seen;
  assign soft_reset_busy = soft_reset_request;

  // Forward gate; whole frame needed in store-and-forward
  assign tx_forward_enable = store_forward_select ? frame_fully_buffered :
    (frame_fully_buffered || (tx_fifo_dwords_valid && tx_fifo_dwords >= tx_threshold_dwords));

  // ----------------------------------------
  // Register and soft reset sequencing
  // ----------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      tx_start_threshold <= `HWCFG_THR_RESET;
      store_forward_select <= `HWCFG_STFWD_RESET;
      tx_ten_meg_select <= `HWCFG_TENM_RESET;
      soft_reset_request <= 1'b0;
      soft_reset_timeout_flag <= 1'b0;
      read_seen <= 1'b0;
      wait_count <= 32'h0;
      mac_soft_reset <= 1'b0;
      system_regs_soft_reset <= 1'b0;
      error_clear <= 1'b0;
      tx_threshold_dwords <= `THR_100_0;
    end else begin
      mac_soft_reset <= 1'b0;
      system_regs_soft_reset <= 1'b0;
      error_clear <= 1'b0;
      tx_threshold_dwords <= threshold_of(tx_ten_meg_select, tx_start_threshold);
      if (power_save_exit)
        read_seen <= 1'b0;
      else if (reg_rd && hit)
        read_seen <= 1'b1;
      case (state)
        ST_IDLE: begin
          // Writes in the wait state are dropped to keep reset atomic
          if (wr_ok) begin
            tx_start_threshold <= reg_wdata[`HWCFG_THR_HI:`HWCFG_THR_LO];
            store_forward_select <= reg_wdata[`HWCFG_STFWD_BIT];
            tx_ten_meg_select <= reg_wdata[`HWCFG_TENM_BIT];
            if (reg_wdata[`HWCFG_REQ_BIT]) begin
              soft_reset_request <= 1'b1;
              wait_count <= 32'h0;
              state <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          // Complete only with PHY clocks running
          if (phy_clocks_running) begin
            mac_soft_reset <= 1'b1;
            // System registers; caller keeps unaffected bits
            system_regs_soft_reset <= 1'b1;
            error_clear <= 1'b1;
            soft_reset_request <= 1'b0;
            soft_reset_timeout_flag <= 1'b0;
            // Configuration fields are MAC defaults too
            tx_start_threshold <= `HWCFG_THR_RESET;
            store_forward_select <= `HWCFG_STFWD_RESET;
            tx_ten_meg_select <= `HWCFG_TENM_RESET;
            state <= ST_IDLE;
          end else if (wait_expired) begin
            // Timeout flag set; host must retry
            soft_reset_timeout_flag <= 1'b1;
            soft_reset_request <= 1'b0;
            state <= ST_IDLE;
          end else begin
            wait_count <= wait_count + 32'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Read data, registered
  // ----------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd && hit) begin
      reg_rdata <= read_word(soft_reset_request, soft_reset_timeout_flag,
        tx_start_threshold, store_forward_select, tx_ten_meg_select);
    end else if (reg_rd) begin
      reg_rdata <= 32'h0;
    end
  end
endmodule // hw_config_soft_reset

/* File: hw_config_soft_reset_chk.sv */
// Assertion checker for the configuration register block
`timescale 1ns/100ps
module hw_config_soft_reset_chk (
  input wire sys_clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire tx_fifo_dwords_valid,
  input wire [8:0] tx_fifo_dwords,
  input wire frame_fully_buffered,
  input wire tx_forward_enable,
  input wire [8:0] tx_threshold_dwords,
  input wire mac_soft_reset,
  input wire system_regs_soft_reset,
  input wire error_clear,
  input wire soft_reset_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_BUSY_CAUSE:
    assert property ($rose(soft_reset_busy) |-> $past(reg_wr) && $past(reg_wdata[0]))
    else $error("busy rose without a request write");
  AST_BUSY_BOUND:
    assert property ($rose(soft_reset_busy) |-> ##[1:40] !soft_reset_busy)
    else $error("request bit did not clear");
  AST_PULSE_ONE:
    assert property (mac_soft_reset |=> !mac_soft_reset) else $error("long reset pulse");
  AST_SYS_PAIR:
    assert property (mac_soft_reset |-> system_regs_soft_reset)
    else $error("system reset missing");
  AST_ERR_PAIR:
    assert property (mac_soft_reset |-> error_clear) else $error("error clear missing");
  AST_PULSE_CAUSE:
    assert property (mac_soft_reset |-> $past(soft_reset_busy)) else $error("stray reset pulse");
  AST_THR_DEF:
    assert property (mac_soft_reset |=> tx_threshold_dwords == 9'h020)
    else $error("threshold not back to default");
  // Below threshold and frame incomplete: never forward in either mode
  AST_FWD_HOLD:
    assert property (tx_fifo_dwords_valid && !frame_fully_buffered &&
      tx_fifo_dwords < tx_threshold_dwords |-> !tx_forward_enable)
    else $error("forwarded below threshold");
endmodule // hw_config_soft_reset_chk
bind hw_config_soft_reset hw_config_soft_reset_chk chk (.*);

/* File: phy_activity.sv */
// PHY clock activity model
`timescale 1ns/100ps
module phy_activity (
  input wire sys_clk,
  input wire run,
  output reg rx_seen,
  output reg tx_seen
);
  initial {rx_seen, tx_seen} = 2'h0;
  always @(posedge sys_clk) begin
    rx_seen <= run & ~rx_seen;
    tx_seen <= run & ~tx_seen;
  end
endmodule // phy_activity

/* File: hw_config_soft_reset_tx_threshold_tb.sv */
// Self-checking bench for the configuration register block
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("MISMATCH %0t %h %h", $time, a, b); end end
module hw_config_soft_reset_tx_threshold_tb;
  logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, pse = 0, run = 1, ffb = 0;
  logic [31:0] wd = 0, rdv;
  logic [8:0] fd = 0, thr;
  logic rx_t, tx_t, fwd, mrst, busy;
  logic [31:0] rdata;
  logic [7:0] ad = 8'h74;
  int err_total = 0, checked = 0, n;
  logic [8:0] tab [8] = '{9'h020, 9'h040, 9'h080, 9'h100, 9'h012, 9'h018, 9'h020, 9'h028};
  phy_activity phy (.sys_clk(sys_clk), .run(run), .rx_seen(rx_t), .tx_seen(tx_t));
  hw_config_soft_reset #(.TIMEOUT_CYCLES(20)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(ad), .reg_wdata(wd), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .power_save_exit(pse), .phy_rx_clk_toggle(rx_t), .phy_tx_clk_toggle(tx_t),
    .tx_fifo_dwords_valid(1'b1), .tx_fifo_dwords(fd), .frame_fully_buffered(ffb),
    .tx_forward_enable(fwd), .tx_threshold_dwords(thr), .mac_soft_reset(mrst),
    .system_regs_soft_reset(), .error_clear(), .soft_reset_busy(busy));
  initial forever #12.5 sys_clk = ~sys_clk;
  task cyc(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  task wr(input [31:0] d);
    cyc(1);
    wd = d;
    reg_wr = 1;
    cyc(1);
    reg_wr = 0;
  endtask
  task rd();
    cyc(1);
    reg_rd = 1;
    cyc(1);
    reg_rd = 0;
    cyc(1);
    rdv = rdata;
  endtask
  task t_gate();
    wr(32'h0000_3000);
    cyc(2);
    `CHK(thr, 9'h020)
    rd();
    wr(32'h0000_3000);
    cyc(2);
    `CHK(thr, 9'h100)
    pse = 1;
    cyc(1);
    pse = 0;
    wr(32'h0);
    cyc(2);
    `CHK(thr, 9'h100)
    rd();
    // Other addresses neither read back nor accept writes
    ad = 8'h78;
    wr(32'h0);
    rd();
    ad = 8'h74;
    cyc(2);
    `CHK(thr, 9'h100)
    `CHK(rdv, 32'h0)
  endtask
  task t_thr();
    rd();
    for (int i = 0; i < 8; i++) begin
      wr(32'((i / 4) << 21 | (i % 4) << 12));
      cyc(2);
      `CHK(thr, tab[i])
      fd = tab[i] - 9'h001;
      cyc(1);
      `CHK(fwd, 1'b0)
      fd = tab[i];
      cyc(1);
      `CHK(fwd, 1'b1)
    end
    // Store-forward waits for the whole frame
    wr(32'h0010_0000);
    fd = 9'h1FF;
    cyc(1);
    `CHK(fwd, 1'b0)
    ffb = 1;
    cyc(1);
    `CHK(fwd, 1'b1)
    ffb = 0;
  endtask
  task t_soft_reset_request(input bit to);
    rd();
    // Success case sets fields so the default restore is visible
    wr(to ? 32'h1 : 32'h0030_3001);
    n = 0;
    repeat (60) begin
      cyc(1);
      n += mrst;
    end
    `CHK(busy, 1'b0)
    `CHK(n, to ? 0 : 1)
    rd();
    `CHK(rdv & (to ? 32'h3 : 32'h0030_3003), to ? 32'h2 : 32'h0)
  endtask
  task test_done();
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    #1 rst_n = 1;
    t_gate();
    t_thr();
    // Stalled PHY forces a timeout on purpose
    run = 0;
    cyc(20);
    t_soft_reset_request(1);
    // retry once the PHY is back
    run = 1;
    cyc(20);
    t_soft_reset_request(0);
    test_done();
  end
  initial begin
    #200000;
    err_total++;
    test_done();
  end
endmodule // hw_config_soft_reset_tx_threshold_tb
